// >>> lmic_defs.svh
// Constants of the laser mode/interlock block
`ifndef LMIC_DEFS_SVH
`define LMIC_DEFS_SVH

`define LMIC_CTRL_OFS        8'h00
`define LMIC_CMD_OFS         8'h04
`define LMIC_STATUS_OFS      8'h08
`define LMIC_POWER_OFS       8'h0c
`define LMIC_NVOPT_OFS       8'h10

`define LMIC_CTRL_AD_BIT     0
`define LMIC_CTRL_EXT_BIT    1
`define LMIC_CTRL_RESET      2'h0

`define LMIC_CMD_EMIT_ON_BIT  0
`define LMIC_CMD_EMIT_OFF_BIT 1
`define LMIC_CMD_GON_BIT     2
`define LMIC_CMD_GOFF_BIT    3
`define LMIC_CMD_PWRON_BIT   4
`define LMIC_CMD_ERRCLR_BIT  5

`define LMIC_ST_MAIN_BIT     0
`define LMIC_ST_READY_BIT    1
`define LMIC_ST_EMIT_BIT     2
`define LMIC_ST_GUIDE_BIT    3
`define LMIC_ST_ERR_BIT      4
`define LMIC_ST_REMOTE_BIT   5
`define LMIC_ST_PROG_BIT     6
`define LMIC_ST_SHORT_BIT    7
`define LMIC_ST_ARMED_BIT    8
`define LMIC_ST_AD_BIT       9

`define LMIC_POWER_RESET     7'h00
`define LMIC_POWER_MAX       7'h64

`define LMIC_CLK_HZ          40000000
`define LMIC_GUIDE_DELAY_MS  10
`define LMIC_GUIDE_CYCLES    ((`LMIC_CLK_HZ / 1000) * `LMIC_GUIDE_DELAY_MS)

`endif

// >>> lmic_pkg.sv
// Types shared by the laser mode/interlock block
package lmic_pkg;

    typedef struct packed {
        logic [31:0] addr;
    } lmic_axi_addr_t;

    typedef struct packed {
        logic        ch_a_closed;
        logic        ch_b_closed;
        logic        stop_pressed;
        logic        start_button;
        logic        fault_detect;
        logic        key_remote;
        logic        laser_request_pin;
        logic        emission_enable_pin;
        logic        guide_request_pin;
        logic        ad_enable_pin;
        logic        emission_gate_input;
        logic [6:0]  program_select;
    } lmic_pins_t;

    typedef struct packed {
        logic        main_power_on;
        logic        ready;
        logic        emission_on;
        logic        guide_on;
        logic        error;
        logic        program_run;
        logic        ad_mode;
        logic        request_echo;
        logic        internal_mode;
        logic [6:0]  power_pct;
    } lmic_outs_t;

    typedef enum logic [1:0] {
        LMIC_LOOP_ARMED   = 2'b00,
        LMIC_LOOP_PARTIAL = 2'b01,
        LMIC_LOOP_OPEN    = 2'b10
    } lmic_loop_t;

endpackage

// >>> lmic_pin_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module lmic_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else if (ce)
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Only a settled level (second and third agree) is passed on
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    pin_out[i] <= 1'b0;
                else if (ce && (s2[i] == s3[i]))
                    pin_out[i] <= s3[i];
            end
        end
    endgenerate
endmodule // lmic_pin_sync

// >>> lmic_top.sv
// Interlock, mode arbitration and AXI4-Lite registers of the laser controller
`timescale 1ns/1ps
`include "lmic_defs.svh"
module lmic_top #(
    parameter int GUIDE_CYCLES = `LMIC_GUIDE_CYCLES
) (
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire logic           ce,
    input  wire logic           s_axi_awvalid,
    output logic                s_axi_awready,
    input  wire logic [31:0]    s_axi_awaddr,
    input  wire logic           s_axi_wvalid,
    output logic                s_axi_wready,
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    output logic                s_axi_bvalid,
    input  wire logic           s_axi_bready,
    output logic [1:0]          s_axi_bresp,
    input  wire logic           s_axi_arvalid,
    output logic                s_axi_arready,
    input  wire logic [31:0]    s_axi_araddr,
    output logic                s_axi_rvalid,
    input  wire logic           s_axi_rready,
    output logic [31:0]         s_axi_rdata,
    output logic [1:0]          s_axi_rresp,
    input  wire lmic_pkg::lmic_pins_t pins,
    input  wire logic [6:0]     analog_pct,
    input  wire logic [6:0]     program_power_pct,
    input  wire logic [1:0]     nv_options,
    output logic [1:0]          nv_options_save,
    output lmic_pkg::lmic_outs_t outs
);
    import lmic_pkg::*;

    lmic_pins_t  sp;
    lmic_loop_t  loop_state;
    logic [1:0]  ctrl;
    logic [6:0]  power_set;
    logic        main_on;
    logic        err_latched;
    logic        short_latched;
    logic        start_prev;
    logic        emit_cmd;
    logic        guide_req;
    logic        guide_lit;
    logic [31:0] guide_cnt;
    logic        gate_prev;
    logic        restored;
    logic        aw_hold;
    logic        w_hold;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [31:0] rd_word;

    // Asynchronous pins: three-stage filter
    lmic_pin_sync #(.W($bits(lmic_pins_t))) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin_in  (pins),
        .pin_out (sp)
    );

    wire logic both_closed = sp.ch_a_closed && sp.ch_b_closed;
    wire logic both_open   = !sp.ch_a_closed && !sp.ch_b_closed;
    wire logic remote      = sp.key_remote;
    wire logic prog_mode   = remote && sp.laser_request_pin
                             && (sp.program_select != 7'h00);
    wire logic ad_mode     = remote ? (sp.laser_request_pin && sp.ad_enable_pin)
                                    : ctrl[`LMIC_CTRL_AD_BIT];
    wire logic ext_mode    = remote ? sp.laser_request_pin
                                    : ctrl[`LMIC_CTRL_EXT_BIT];
    wire logic armed       = (loop_state == LMIC_LOOP_ARMED);
    wire logic ready       = main_on && !guide_lit;

    // Register write decode
    wire logic wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    wire logic [7:0] wr_ofs = aw_addr[7:0];
    wire logic cmd_wr  = wr_fire && (wr_ofs == `LMIC_CMD_OFS) && w_strb[0];
    wire logic [5:0] cmd = cmd_wr ? w_data[5:0] : 6'h00;

    // AXI write address and data accepted in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 32'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_hold <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_hold <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end
        else if (ce)
        begin
            s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_hold && !(s_axi_wvalid && s_axi_wready);
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_ofs == `LMIC_CTRL_OFS || wr_ofs == `LMIC_CMD_OFS
                                 || wr_ofs == `LMIC_POWER_OFS) && aw_addr[31:8] == 24'h0
                                ? 2'b00 : 2'b10;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Options restored from retained storage at start-up
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl     <= `LMIC_CTRL_RESET;
            restored <= 1'b0;
        end
        else if (ce)
        begin
            if (!restored)
            begin
                ctrl     <= nv_options;
                restored <= 1'b1;
            end
            else if (wr_fire && wr_ofs == `LMIC_CTRL_OFS && w_strb[0] && !remote)
                ctrl <= w_data[1:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            nv_options_save <= `LMIC_CTRL_RESET;
        else if (ce)
            nv_options_save <= ctrl;
    end

    // Power set value in percent, clamped to full power
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            power_set <= `LMIC_POWER_RESET;
        else if (ce && wr_fire && wr_ofs == `LMIC_POWER_OFS && w_strb[0])
            power_set <= (w_data > {25'h0, `LMIC_POWER_MAX}) ? `LMIC_POWER_MAX
                                                         : w_data[6:0];
    end

    // Interlock loop: a single opened channel forces a full open/close cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            loop_state <= LMIC_LOOP_OPEN;
        else if (ce)
        begin
            case (loop_state)
                LMIC_LOOP_ARMED:
                    if (both_open)
                        loop_state <= LMIC_LOOP_OPEN;
                    else if (!both_closed)
                        loop_state <= LMIC_LOOP_PARTIAL;
                LMIC_LOOP_PARTIAL:
                    if (both_open)
                        loop_state <= LMIC_LOOP_OPEN;
                LMIC_LOOP_OPEN:
                    if (both_closed && !short_latched)
                        loop_state <= LMIC_LOOP_ARMED;
                default:
                    loop_state <= LMIC_LOOP_OPEN;
            endcase
        end
    end

    // Short: channels disagree with stop pressed while loop open, or start pressed while not armed
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            short_latched <= 1'b0;
            err_latched   <= 1'b0;
        end
        else if (ce)
        begin
            // Set wins over a clear in the same cycle
            if (sp.fault_detect)
                err_latched <= 1'b1;
            else if (cmd[`LMIC_CMD_ERRCLR_BIT])
                err_latched <= 1'b0;
            if ((sp.ch_a_closed != sp.ch_b_closed && loop_state == LMIC_LOOP_OPEN
                 && sp.stop_pressed) || (sp.start_button && !start_prev && !armed))
                short_latched <= 1'b1;
            else if (cmd[`LMIC_CMD_ERRCLR_BIT] && !sp.start_button)
                short_latched <= 1'b0;
        end
    end

    // Main power contactor
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            main_on    <= 1'b0;
            start_prev <= 1'b0;
        end
        else if (ce)
        begin
            start_prev <= sp.start_button;
            if (!armed || !both_closed || err_latched || short_latched || sp.fault_detect)
                main_on <= 1'b0;
            else if (!sp.stop_pressed && ((sp.start_button && !start_prev)
                     || cmd[`LMIC_CMD_PWRON_BIT]))
                main_on <= 1'b1;
        end
    end

    // Command emission latch, dropped whenever ready goes away
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            emit_cmd  <= 1'b0;
            gate_prev <= 1'b0;
        end
        else if (ce)
        begin
            gate_prev <= sp.emission_gate_input;
            if (!ready || cmd[`LMIC_CMD_EMIT_OFF_BIT])
                emit_cmd <= 1'b0;
            else if (cmd[`LMIC_CMD_EMIT_ON_BIT])
                emit_cmd <= 1'b1;
        end
    end

    // Guide request source per mode, applied after the switching delay
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            guide_req <= 1'b0;
        else if (ce)
        begin
            if (remote && ext_mode)
                guide_req <= sp.laser_request_pin && sp.guide_request_pin;
            else if (cmd[`LMIC_CMD_GOFF_BIT])
                guide_req <= 1'b0;
            else if (cmd[`LMIC_CMD_GON_BIT])
                guide_req <= 1'b1;
        end
    end

    // Guide module is slow; a change only lands after the full delay
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            guide_lit <= 1'b0;
            guide_cnt <= 32'h0;
        end
        else if (ce)
        begin
            if (guide_req == guide_lit)
                guide_cnt <= 32'h0;
            else if (guide_cnt >= 32'(GUIDE_CYCLES - 1))
            begin
                guide_lit <= guide_req;
                guide_cnt <= 32'h0;
            end
            else
                guide_cnt <= guide_cnt + 32'h1;
        end
    end

    // Output selection
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            outs <= '0;
        else if (ce)
        begin
            outs.main_power_on <= main_on;
            outs.ready         <= ready;
            outs.guide_on      <= guide_lit;
            outs.error         <= err_latched || short_latched;
            outs.ad_mode       <= ad_mode;
            outs.request_echo  <= sp.laser_request_pin;
            outs.internal_mode <= !ext_mode;
            outs.program_run   <= ready && prog_mode && sp.emission_enable_pin;
            if (!ready)
                outs.emission_on <= 1'b0;
            else if (prog_mode)
                outs.emission_on <= sp.emission_enable_pin;
            else if (ext_mode && remote)
                outs.emission_on <= sp.emission_enable_pin
                                    && sp.emission_gate_input;
            else if (ext_mode)
                outs.emission_on <= sp.emission_gate_input;
            else
                outs.emission_on <= emit_cmd;
            if (prog_mode)
                outs.power_pct <= program_power_pct;
            else if (ad_mode)
                outs.power_pct <= analog_pct;
            else
                outs.power_pct <= power_set;
        end
    end

    // Read mux
    always_comb
    begin
        rd_word = 32'h0;
        case (s_axi_araddr[7:0])
            `LMIC_CTRL_OFS:   rd_word = {30'h0, ctrl};
            `LMIC_POWER_OFS:  rd_word = {25'h0, power_set};
            `LMIC_STATUS_OFS:
            begin
                rd_word[`LMIC_ST_MAIN_BIT]  = main_on;
                rd_word[`LMIC_ST_READY_BIT] = ready;
                rd_word[`LMIC_ST_EMIT_BIT]  = outs.emission_on;
                rd_word[`LMIC_ST_GUIDE_BIT] = guide_lit;
                rd_word[`LMIC_ST_ERR_BIT]   = err_latched;
                rd_word[`LMIC_ST_REMOTE_BIT] = remote;
                rd_word[`LMIC_ST_PROG_BIT]  = prog_mode;
                rd_word[`LMIC_ST_SHORT_BIT] = short_latched;
                rd_word[`LMIC_ST_ARMED_BIT] = armed;
                rd_word[`LMIC_ST_AD_BIT]    = ad_mode;
            end
            default:          rd_word = 32'h0;
        endcase
    end

    wire logic rd_ok = (s_axi_araddr[31:8] == 24'h0)
                       && (s_axi_araddr[7:0] == `LMIC_CTRL_OFS
                           || s_axi_araddr[7:0] == `LMIC_POWER_OFS
                           || s_axi_araddr[7:0] == `LMIC_STATUS_OFS
                           || s_axi_araddr[7:0] == `LMIC_CMD_OFS);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'b00;
        end
        else if (ce)
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_word : 32'h0;
                s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // lmic_top

// >>> lmic_checker.sv
// Port assertions of the laser block
`timescale 1ns/1ps
module lmic_checker #(
    parameter int GUIDE_CYCLES = 16
) (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_araddr,
    input wire logic                 s_axi_rvalid,
    input wire logic [1:0]           s_axi_rresp,
    input wire lmic_pkg::lmic_pins_t pins,
    input wire logic [6:0]           analog_pct,
    input wire lmic_pkg::lmic_outs_t outs
);
    import lmic_pkg::*;
    logic [15:0] since_req;
    logic [3:0]  wr_age;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Any write or request pin edge restarts the guide timing
    always_ff @(posedge aclk)
    begin
        if (!aresetn || (s_axi_wvalid && s_axi_wready) || $changed(pins.guide_request_pin)
            || $changed(pins.laser_request_pin) || $changed(pins.key_remote))
            since_req <= 16'h0;
        else if (since_req != 16'hffff)
            since_req <= since_req + 16'h1;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn || (s_axi_wvalid && s_axi_wready))
            wr_age <= 4'h0;
        else if (wr_age != 4'hf)
            wr_age <= wr_age + 4'h1;
    end
    open_drop_a: assert property ((!pins.ch_a_closed)[*8] |-> ##2 !outs.main_power_on)
        else $error("main power held with channel open");
    start_closed_a: assert property ($rose(outs.main_power_on) |->
        $past(pins.ch_a_closed, 3) && $past(pins.ch_b_closed, 3))
        else $error("main power rose with channel open");
    fault_latch_a: assert property (pins.fault_detect[*8] |->
        ##2 (outs.error && !outs.main_power_on))
        else $error("fault did not set error or drop power");
    err_hold_a: assert property ($fell(outs.error) |-> wr_age < 4'h6)
        else $error("error cleared without a command");
    guide_ready_a: assert property (outs.guide_on |-> !outs.ready)
        else $error("ready with guide lit");
    guide_delay_a: assert property ($changed(outs.guide_on) |-> since_req >= GUIDE_CYCLES)
        else $error("guide switched too early");
    emit_off_a: assert property ((!outs.ready)[*3] |-> !outs.emission_on)
        else $error("emission without ready");
    power_clamp_a: assert property (outs.power_pct <= 7'h64)
        else $error("power above full scale");
    ad_follow_a: assert property ((outs.ad_mode && $stable(analog_pct))[*6] |->
        outs.power_pct == analog_pct)
        else $error("power not following analog input");
    bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h20
        |=> s_axi_rvalid && s_axi_rresp == 2'b10)
        else $error("unmapped read not refused");
endmodule // lmic_checker

bind lmic_top lmic_checker #(.GUIDE_CYCLES(GUIDE_CYCLES)) lmic_checker_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp), .pins(pins),
    .analog_pct(analog_pct), .outs(outs)
);

// >>> lmic_board.sv
// Machine control board model driving the laser control pins
`timescale 1ns/1ps
module lmic_board (
    input wire logic            aclk,
    output lmic_pkg::lmic_pins_t pins
);
    import lmic_pkg::*;
    initial pins = '0;
    task automatic loop(input logic a, input logic b);
        @(posedge aclk);
        pins.ch_a_closed <= a;
        pins.ch_b_closed <= b;
        repeat (10) @(posedge aclk);
    endtask
    // Held well past the pin filter so one press is never missed
    task automatic press;
        @(posedge aclk);
        pins.start_button <= 1'b1;
        repeat (8) @(posedge aclk);
        pins.start_button <= 1'b0;
        repeat (10) @(posedge aclk);
    endtask
    task automatic fault(input logic f);
        @(posedge aclk);
        pins.fault_detect <= f;
        repeat (10) @(posedge aclk);
    endtask
    task automatic remote(input logic k, rq, en, gd, gate, input logic [6:0] prog);
        @(posedge aclk);
        pins.key_remote <= k;
        pins.laser_request_pin <= rq;
        pins.emission_enable_pin <= en;
        pins.guide_request_pin <= gd;
        pins.emission_gate_input <= gate;
        pins.program_select <= prog;
    endtask
endmodule // lmic_board

// >>> test_laser_mode_interlock_control.sv
// Self-checking bench for the laser interlock block
`timescale 1ns/1ps
`include "lmic_defs.svh"
module test_laser_mode_interlock_control;
    import lmic_pkg::*;
    localparam logic [15:0] MAIN = 16'h8000, RDY = 16'h4000, EMIT = 16'h2000;
    localparam logic [15:0] GUIDE = 16'h1000, ERR = 16'h0800, PROG = 16'h0400;
    localparam logic [15:0] AD = 16'h0200, PWR = 16'h007f;
    logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0]  bresp, rresp, nvo, nvs;
    logic [6:0]  ana, ppct;
    lmic_pins_t  pins;
    lmic_outs_t  outs;
    int          err_count, compares;
    logic [31:0] d;
    logic [1:0]  r;
    lmic_top #(.GUIDE_CYCLES(16)) lmic_top_i (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .pins(pins), .analog_pct(ana), .program_power_pct(ppct),
        .nv_options(nvo), .nv_options_save(nvs), .outs(outs)
    );
    lmic_board lmic_board_i (.aclk(aclk), .pins(pins));
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic summarize;
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input string nm, input logic [15:0] m, input logic [15:0] v);
        int n;
        n = 0;
        do
            @(negedge aclk);
        while ((outs & m) !== v && ++n < 80);
        chk(nm, v, outs & m);
    endtask
    // Handshakes judged at the falling edge, where registered outputs are settled
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        logic [1:0] br;
        int n;
        hb = 1'b0;
        br = 2'h3;
        n = 0;
        @(posedge aclk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        while (!hb && n < 50)
        begin
            @(negedge aclk);
            {ha, hw, hb, br} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            n++;
            @(posedge aclk);
            {awvalid, wvalid, bready} <= {awvalid & !ha, wvalid & !hw, !hb};
        end
        chk("bresp", 32'h0, br);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        int n;
        hr = 1'b0;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        while (!hr && n < 50)
        begin
            @(negedge aclk);
            {ha, hr, d, r} = {arvalid & arready, rvalid, rdata, rresp};
            n++;
            @(posedge aclk);
            {arvalid, rready} <= {arvalid & !ha, !hr};
        end
        if (!hr)
            chk("rvalid", 32'h1, 32'h0);
    endtask
    task automatic rst(input logic [1:0] nv);
        @(posedge aclk);
        aresetn <= 1'b0;
        nvo <= nv;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask
    task automatic t_regs;
        rd(`LMIC_STATUS_OFS, d, r);
        chk("status", 32'h0, d);
        rd(32'h20, d, r);
        chk("bad rresp", 32'h2, r);
        chk("bad rdata", 32'h0, d);
        wr(`LMIC_POWER_OFS, 32'h32);
        wt("power", PWR, 16'h0032);
        rd(`LMIC_POWER_OFS, d, r);
        chk("power reg", 32'h32, d);
        wr(`LMIC_POWER_OFS, 32'hc8);
        wt("clamp", PWR, 16'h0064);
    endtask
    task automatic t_lock;
        lmic_board_i.loop(1'b1, 1'b1);
        lmic_board_i.press();
        wt("start", MAIN, MAIN);
        lmic_board_i.loop(1'b0, 1'b1);
        wt("one open", MAIN, 16'h0);
        lmic_board_i.loop(1'b1, 1'b1);
        lmic_board_i.press();
        wt("partial", MAIN | ERR, ERR);
        lmic_board_i.loop(1'b0, 1'b0);
        lmic_board_i.loop(1'b1, 1'b1);
        lmic_board_i.press();
        wt("short held", MAIN | ERR, ERR);
        wr(`LMIC_CMD_OFS, 32'h20);
        wt("short clr", ERR, 16'h0);
        lmic_board_i.press();
        wt("rearmed", MAIN, MAIN);
    endtask
    task automatic t_err;
        lmic_board_i.fault(1'b1);
        wt("fault", MAIN | ERR, ERR);
        lmic_board_i.fault(1'b0);
        lmic_board_i.press();
        wt("blocked", MAIN | ERR, ERR);
        wr(`LMIC_CMD_OFS, 32'h20);
        wt("err clr", ERR, 16'h0);
        lmic_board_i.press();
        wt("restart", MAIN, MAIN);
    endtask
    task automatic t_emit;
        wt("ready", RDY, RDY);
        wr(`LMIC_CMD_OFS, 32'h1);
        wt("emit on", EMIT, EMIT);
        wr(`LMIC_CMD_OFS, 32'h2);
        wt("emit off", EMIT, 16'h0);
        wr(`LMIC_CTRL_OFS, 32'h2);
        lmic_board_i.remote(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 7'h0);
        wt("gate 1", EMIT, EMIT);
        lmic_board_i.remote(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h0);
        wt("gate 0", EMIT, 16'h0);
        lmic_board_i.remote(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 7'h0);
        wt("gate 1b", EMIT, EMIT);
        lmic_board_i.loop(1'b0, 1'b1);
        wt("forced off", MAIN | EMIT, 16'h0);
        lmic_board_i.remote(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h0);
        wr(`LMIC_CTRL_OFS, 32'h0);
        lmic_board_i.loop(1'b0, 1'b0);
        lmic_board_i.loop(1'b1, 1'b1);
        lmic_board_i.press();
        wt("power back", MAIN, MAIN);
    endtask
    task automatic t_guide;
        wr(`LMIC_CMD_OFS, 32'h4);
        chk("guide early", 32'h0, outs.guide_on);
        wt("guide on", GUIDE | RDY, GUIDE);
        wr(`LMIC_CMD_OFS, 32'h8);
        wt("guide off", GUIDE | RDY, RDY);
        lmic_board_i.remote(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 7'h0);
        repeat (40) @(negedge aclk);
        chk("guide pins", 32'h0, outs.guide_on);
    endtask
    task automatic t_ad;
        wr(`LMIC_CTRL_OFS, 32'h1);
        wt("analog", AD | PWR, AD | 16'h002a);
        chk("nv save", 32'h1, nvs);
        wr(`LMIC_CTRL_OFS, 32'h0);
        wt("set power", AD | PWR, 16'h0064);
    endtask
    task automatic t_remote;
        lmic_board_i.remote(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 7'h0);
        wt("rem guide", GUIDE, GUIDE);
        wr(`LMIC_CTRL_OFS, 32'h1);
        rd(`LMIC_CTRL_OFS, d, r);
        chk("rem ctrl", 32'h0, d);
        lmic_board_i.remote(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 7'h0);
        wt("rem guide 0", GUIDE, 16'h0);
        lmic_board_i.remote(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 7'h05);
        wt("program", PROG | PWR, PROG | 16'h0021);
        lmic_board_i.remote(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h0);
        wt("program 0", PROG, 16'h0);
    endtask
    task automatic t_nv;
        rst(2'h1);
        rd(`LMIC_CTRL_OFS, d, r);
        chk("nv restore", 32'h1, d);
    endtask
    initial
    begin
        err_count = 0;
        compares = 0;
        aresetn = 1'b0;
        ce = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, wdata, araddr} = '0;
        nvo = 2'h0;
        ana = 7'h2a;
        ppct = 7'h21;
        rst(2'h0);
        t_regs();
        t_lock();
        t_err();
        t_emit();
        t_guide();
        t_ad();
        t_remote();
        t_nv();
        summarize();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (40000) @(posedge aclk);
        err_count++;
        summarize();
    end
endmodule // test_laser_mode_interlock_control
